// file: design/sofs_pkg.sv
// Shared types and constants for the serial output format select block.
// Assumes a single 250 MHz core clock and an asynchronous active-low reset.
package sofs_pkg;
   localparam logic [12:0] ADDR_SER_CTL = 13'h021;
   localparam logic [12:0] ADDR_UIO3 = 13'h102;
   localparam logic [7:0] RST_SER_CTL = 8'h30;
   localparam logic [7:0] RST_UIO3 = 8'h00;
   localparam logic [7:0] CTL_BAD_MASK = 8'h89;
   localparam logic [7:0] CTL_ONELANE_CLR = 8'h34;
   localparam int UIO3_VCM_PD_BIT = 3;
   localparam int CTL_ONELANE_BIT = 6;
   localparam int CTL_DDR_BIT = 5;
   localparam int CTL_BYTE_BIT = 4;
   localparam int CTL_FRAME2X_BIT = 2;
   localparam int CTL_W12_BIT = 1;
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int SLOT_CYCLES = 2;
   localparam int SLOT_HALF = 1;
   localparam int SPI_INSTR_BITS = 16;
   localparam int SPI_TOTAL_BITS = 24;

   typedef enum logic {SOFS_IDLE, SOFS_SHIFT} sofs_fsm_t;

   typedef struct packed {
      logic word12;
      logic frame2x;
      logic bytewise;
      logic onelane;
      logic ddr;
   } sofs_mode_t;

   typedef struct packed {
      logic strobe;
      logic [12:0] addr;
      logic [7:0] data;
   } sofs_regwr_t;

   typedef struct packed {
      logic data_clock_out;
      logic frame_clock_out;
      logic [1:0] lane;
   } sofs_link_t;
endpackage

// file: design/sofs_fifo.sv
// Sample FIFO between the converter side and the serializer.
// Assumes both sides run on clk_i; valid/ready handshake on each side.
`timescale 1ns/1ps
`default_nettype none
module sofs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } sofs_fifo_st_t;

   sofs_fifo_st_t st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop, full, empty;

   assign full = (st_reg.wptr[AW] != st_reg.rptr[AW]) &&
                 (st_reg.wptr[AW-1:0] == st_reg.rptr[AW-1:0]);
   assign empty = st_reg.wptr == st_reg.rptr;
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[st_reg.rptr[AW-1:0]];
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wptr = st_reg.wptr + 1'b1;
      end
      if (pop) begin
         st_next.rptr = st_reg.rptr + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage needs no reset; empty flag guards stale words
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[st_reg.wptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// file: design/sofs_spi_port.sv
// Three-wire serial control port: 16-bit instruction, one data byte.
// Assumes pins are asynchronous; sclk is far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module sofs_spi_port (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic spi_sclk_i,
   input wire logic port_select_low_i,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_b_o,
   output logic [12:0] rd_addr_o,
   input wire logic [7:0] rd_data_i,
   output sofs_pkg::sofs_regwr_t wr_o
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic sclk_prev;
      logic [4:0] cnt;
      logic [15:0] instr;
      logic [7:0] shreg;
      logic drive;
      logic sdo;
      sofs_pkg::sofs_regwr_t wr;
   } sofs_spi_st_t;

   sofs_spi_st_t st_reg, st_next;
   logic sclk_s, csb_s, sdi_s, rise, fall;

   assign sclk_s = st_reg.sync[2];
   assign csb_s = st_reg.sync[1];
   assign sdi_s = st_reg.sync[0];
   assign rise = sclk_s && !st_reg.sclk_prev;
   assign fall = !sclk_s && st_reg.sclk_prev;

   always_comb begin
      st_next = st_reg;
      st_next.meta = {spi_sclk_i, port_select_low_i, sdio_i};
      st_next.sync = st_reg.meta;
      st_next.sclk_prev = sclk_s;
      st_next.wr.strobe = 1'b0;
      if (csb_s) begin
         st_next.cnt = '0;
         st_next.drive = 1'b0;
      end else if (rise && st_reg.cnt < 5'(sofs_pkg::SPI_TOTAL_BITS)) begin
         st_next.cnt = st_reg.cnt + 5'd1;
         if (st_reg.cnt < 5'(sofs_pkg::SPI_INSTR_BITS)) begin
            st_next.instr = {st_reg.instr[14:0], sdi_s};
         end else if (!st_reg.instr[15]) begin
            st_next.shreg = {st_reg.shreg[6:0], sdi_s};
            if (st_reg.cnt == 5'(sofs_pkg::SPI_TOTAL_BITS - 1)) begin
               st_next.wr.strobe = 1'b1;
               st_next.wr.addr = st_reg.instr[12:0];
               st_next.wr.data = {st_reg.shreg[6:0], sdi_s};
            end
         end
      end else if (fall && st_reg.instr[15] &&
                   st_reg.cnt >= 5'(sofs_pkg::SPI_INSTR_BITS)) begin
         // Read data leaves on falling edges so the host samples on rising
         st_next.drive = st_reg.cnt < 5'(sofs_pkg::SPI_TOTAL_BITS);
         if (st_reg.cnt == 5'(sofs_pkg::SPI_INSTR_BITS)) begin
            st_next.sdo = rd_data_i[7];
            st_next.shreg = {rd_data_i[6:0], 1'b0};
         end else begin
            st_next.sdo = st_reg.shreg[7];
            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Idle pin levels: clock low, select high, data low; no false edge
         st_reg <= '{meta: 3'h2, sync: 3'h2, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sdio_o = st_reg.sdo;
   assign sdio_oe_b_o = !st_reg.drive;
   assign rd_addr_o = st_reg.instr[12:0];
   assign wr_o = st_reg.wr;
endmodule
`default_nettype wire

// file: design/sofs_top.sv
// Serial output format select: register file and lane serializer.
// Assumes sample_clk_i is asynchronous with a period well above 40 ns;
// converted samples arrive on clk_i through a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
module sofs_top #(
   parameter int SAMPLE_W = sofs_pkg::SAMPLE_W,
   parameter int FIFO_DEPTH = sofs_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic sample_clk_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [SAMPLE_W-1:0] sample_data_i,
   input wire logic spi_sclk_i,
   input wire logic port_select_low_i,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_b_o,
   output sofs_pkg::sofs_link_t link_o,
   output logic common_mode_reference_pd_o
);
   typedef struct packed {
      logic smp_meta;
      logic smp_sync;
      logic smp_prev;
      logic [7:0] ctl;
      logic [7:0] uio3;
      logic ctl_touched;
      logic [7:0] code;
      sofs_pkg::sofs_mode_t mode;
      sofs_pkg::sofs_fsm_t fsm;
      logic [15:0] word;
      logic [15:0] sh_a;
      logic [15:0] sh_b;
      logic [4:0] slot;
      logic [4:0] nslot;
      logic [1:0] phase;
      logic pair_odd;
      logic [4:0] dco_rises;
      logic busy_prev;
      sofs_pkg::sofs_link_t link;
   } sofs_st_t;

   sofs_st_t st_reg, st_next;
   sofs_pkg::sofs_regwr_t wr;
   logic [12:0] rd_addr;
   logic [7:0] rd_data;
   logic fifo_valid, fifo_pop, smp_edge, busy;
   logic [SAMPLE_W-1:0] fifo_data;
   logic [15:0] w16;

   // Unlisted codes fall back to the default format
   function automatic sofs_pkg::sofs_mode_t decode_mode(input logic [7:0] c);
      logic [7:0] v;
      v = c;
      if ((c & sofs_pkg::CTL_BAD_MASK) != 8'h00 ||
          (c[sofs_pkg::CTL_ONELANE_BIT] && (c & sofs_pkg::CTL_ONELANE_CLR) != 8'h00)) begin
         v = sofs_pkg::RST_SER_CTL;
      end
      decode_mode.word12 = v[sofs_pkg::CTL_W12_BIT];
      decode_mode.frame2x = v[sofs_pkg::CTL_FRAME2X_BIT];
      decode_mode.bytewise = v[sofs_pkg::CTL_BYTE_BIT];
      decode_mode.onelane = v[sofs_pkg::CTL_ONELANE_BIT];
      // One-lane output is always double data rate
      decode_mode.ddr = v[sofs_pkg::CTL_DDR_BIT] | v[sofs_pkg::CTL_ONELANE_BIT];
   endfunction

   function automatic logic [4:0] slots_per_lane(input sofs_pkg::sofs_mode_t m);
      logic [4:0] bits;
      bits = m.word12 ? 5'd12 : 5'd16;
      slots_per_lane = m.onelane ? bits : (bits >> 1);
   endfunction

   function automatic logic [31:0] split_bits(input logic [15:0] w);
      logic [15:0] a;
      logic [15:0] b;
      a = '0;
      b = '0;
      for (int i = 0; i < 8; i++) begin
         a[15-i] = w[15-2*i];
         b[15-i] = w[14-2*i];
      end
      split_bits = {a, b};
   endfunction

   sofs_spi_port u_spi (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .spi_sclk_i(spi_sclk_i),
      .port_select_low_i(port_select_low_i),
      .sdio_i(sdio_i),
      .sdio_o(sdio_o),
      .sdio_oe_b_o(sdio_oe_b_o),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .wr_o(wr)
   );

   // Samples wait here; the idle serializer drains one per rising sample clock edge
   sofs_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i(sample_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   assign rd_data = (rd_addr == sofs_pkg::ADDR_SER_CTL) ? st_reg.ctl :
                    (rd_addr == sofs_pkg::ADDR_UIO3) ? st_reg.uio3 : 8'h00;
   assign smp_edge = st_reg.smp_sync && !st_reg.smp_prev;
   assign busy = st_reg.fsm == sofs_pkg::SOFS_SHIFT;
   assign fifo_pop = !busy && smp_edge && fifo_valid;
   assign w16 = 16'(fifo_data);

   always_comb begin
      st_next = st_reg;
      st_next.smp_meta = sample_clk_i;
      st_next.smp_sync = st_reg.smp_meta;
      st_next.smp_prev = st_reg.smp_sync;
      st_next.busy_prev = busy;
      if (wr.strobe && wr.addr == sofs_pkg::ADDR_SER_CTL) begin
         st_next.ctl = wr.data;
         st_next.ctl_touched = 1'b1;
      end
      if (wr.strobe && wr.addr == sofs_pkg::ADDR_UIO3) begin
         st_next.uio3 = wr.data;
      end
      unique case (st_reg.fsm)
         sofs_pkg::SOFS_IDLE: begin
            st_next.link = '0;
            if (fifo_pop) begin
               // Format changes take effect only at a word boundary
               st_next.code = st_reg.ctl;
               st_next.mode = decode_mode(st_reg.ctl);
               st_next.nslot = slots_per_lane(st_next.mode);
               st_next.word = w16;
               if (st_next.mode.onelane) begin
                  st_next.sh_a = w16;
                  st_next.sh_b = '0;
               end else if (st_next.mode.bytewise) begin
                  st_next.sh_a = w16;
                  st_next.sh_b = w16 << st_next.nslot;
               end else begin
                  {st_next.sh_a, st_next.sh_b} = split_bits(w16);
               end
               st_next.slot = '0;
               st_next.phase = '0;
               st_next.dco_rises = '0;
               st_next.pair_odd = st_reg.pair_odd ^ st_next.mode.frame2x;
               st_next.fsm = sofs_pkg::SOFS_SHIFT;
            end
         end
         sofs_pkg::SOFS_SHIFT: begin
            if (st_reg.phase == 2'd0) begin
               st_next.link.lane = {st_reg.sh_b[15], st_reg.sh_a[15]};
               st_next.sh_a = st_reg.sh_a << 1;
               st_next.sh_b = st_reg.sh_b << 1;
               // 2x frame: one frame clock period spans two words
               st_next.link.frame_clock_out = st_reg.mode.frame2x ?
                  st_reg.pair_odd : (st_reg.slot < (st_reg.nslot >> 1));
               if (!st_reg.mode.ddr) begin
                  st_next.link.data_clock_out = 1'b0;
               end
            end
            if (st_reg.phase == 2'(sofs_pkg::SLOT_HALF)) begin
               // Clock edge centred in the bit slot
               st_next.link.data_clock_out = st_reg.mode.ddr ?
                  !st_reg.link.data_clock_out : 1'b1;
            end
            if (st_next.link.data_clock_out && !st_reg.link.data_clock_out) begin
               st_next.dco_rises = st_reg.dco_rises + 5'd1;
            end
            if (st_reg.phase == 2'(sofs_pkg::SLOT_CYCLES - 1)) begin
               st_next.phase = '0;
               st_next.slot = st_reg.slot + 5'd1;
               if (st_reg.slot == st_reg.nslot - 5'd1) begin
                  st_next.fsm = sofs_pkg::SOFS_IDLE;
               end
            end else begin
               st_next.phase = st_reg.phase + 2'd1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '{ctl: sofs_pkg::RST_SER_CTL, uio3: sofs_pkg::RST_UIO3,
                     fsm: sofs_pkg::SOFS_IDLE, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign link_o = st_reg.link;
   assign common_mode_reference_pd_o = st_reg.uio3[sofs_pkg::UIO3_VCM_PD_BIT];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   logic frame_end;
   // Registered copy of busy keeps sampled-value calls out of nets
   assign frame_end = !busy && st_reg.busy_prev;

   a_default_code: assert property (!st_reg.ctl_touched |-> st_reg.ctl == 8'h30)
      else $error("control register left its default without a write");
   a_ddr16_clock: assert property (frame_end && st_reg.code == 8'h30 |->
      st_reg.dco_rises == 5'd4)
      else $error("default mode clock multiple wrong");
   a_sdr16_clock: assert property (frame_end && st_reg.code == 8'h10 |->
      st_reg.dco_rises == 5'd8)
      else $error("sdr 16-bit clock multiple wrong");
   a_frame2x_clock: assert property (frame_end && st_reg.code == 8'h34 |->
      st_reg.dco_rises == 5'd4 && st_reg.mode.frame2x)
      else $error("2x frame mode wrong");
   a_bitwise_first: assert property ($rose(busy) && st_reg.code == 8'h20 |->
      ##1 st_reg.link.lane == {st_reg.word[14], st_reg.word[15]})
      else $error("bitwise lane split wrong");
   a_onelane_clock: assert property (frame_end && st_reg.code == 8'h40 |->
      st_reg.dco_rises == 5'd8)
      else $error("one-lane 16-bit clock multiple wrong");
   a_word12_clock: assert property (frame_end && st_reg.code == 8'h32 |->
      st_reg.dco_rises == 5'd3)
      else $error("12-bit ddr clock multiple wrong");
   a_sdr12_clock: assert property (frame_end && st_reg.code == 8'h16 |->
      st_reg.dco_rises == 5'd6)
      else $error("12-bit sdr 2x clock multiple wrong");
   a_onelane12_clock: assert property (frame_end && st_reg.code == 8'h42 |->
      st_reg.dco_rises == 5'd6)
      else $error("one-lane 12-bit clock multiple wrong");
   a_vcm_powerdown: assert property (wr.strobe && wr.addr == 13'h102 |=>
      common_mode_reference_pd_o == $past(wr.data[3]))
      else $error("reference power-down does not follow write");
   a_ctl_update: assert property (wr.strobe && wr.addr == 13'h021 |=>
      st_reg.ctl == $past(wr.data))
      else $error("control register write lost");
   a_frame_mark: assert property ($rose(busy) && !st_reg.mode.frame2x |->
      ##1 link_o.frame_clock_out [*2])
      else $error("frame clock missing at word start");

   c_default_frame: cover property (frame_end && st_reg.code == 8'h30);
   c_onelane_frame: cover property (frame_end && st_reg.code == 8'h40);
   c_sdr12_frame: cover property (frame_end && st_reg.code == 8'h16);
   c_fifo_full: cover property (!sample_ready_o);
endmodule
`default_nettype wire

// file: tb/sofs_capture.sv
// Capture-side model of the lane receiver; rebuilds each word.
// Assumes link_i is sampled on clk_i and mode_i is held between frames.
`timescale 1ns/1ps
`default_nettype none
module sofs_capture (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire sofs_pkg::sofs_link_t link_i,
   input wire sofs_pkg::sofs_mode_t mode_i,
   output logic word_valid_o,
   output logic [15:0] word_o,
   output logic [4:0] rises_o,
   output logic frame_o
);
   logic [15:0] sh0, sh1, s0, s1, w;
   logic [4:0] n, cnt, rises;
   logic dclk_q, fclk_q, fr_first, rise, take;
   always_comb begin
      n = mode_i.onelane ? (mode_i.word12 ? 5'd12 : 5'd16) : (mode_i.word12 ? 5'd6 : 5'd8);
      rise = link_i.data_clock_out && !dclk_q;
      // Both edges in double rate, rising edge only in single rate
      take = mode_i.ddr ? (link_i.data_clock_out != dclk_q) : rise;
      s0 = {sh0[14:0], link_i.lane[0]};
      s1 = {sh1[14:0], link_i.lane[1]};
      w = mode_i.onelane ? s0 : {s0[7:0], s1[7:0]};
      if (mode_i.word12) begin
         w = mode_i.onelane ? {s0[11:0], 4'h0} : {s0[5:0], s1[5:0], 4'h0};
      end
      if (!mode_i.bytewise && !mode_i.onelane) begin
         w = 16'h0000;
         for (int i = 0; i < 8; i++) begin
            if (i < n) begin
               w[15-2*i] = s0[n-1-i];
               w[14-2*i] = s1[n-1-i];
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {sh0, sh1, cnt, rises, dclk_q, fclk_q, fr_first} <= '0;
         {word_valid_o, word_o, rises_o, frame_o} <= '0;
      end else begin
         word_valid_o <= 1'b0;
         dclk_q <= link_i.data_clock_out;
         fclk_q <= link_i.frame_clock_out;
         if (rise) rises <= rises + 5'd1;
         // Word boundary realigned on each frame clock rise
         if (link_i.frame_clock_out && !fclk_q) cnt <= 5'd0;
         if (take) begin
            sh0 <= s0;
            sh1 <= s1;
            cnt <= cnt + 5'd1;
            if (cnt == 5'd0) fr_first <= link_i.frame_clock_out;
            if (cnt == n - 5'd1) begin
               cnt <= 5'd0;
               rises <= 5'd0;
               word_valid_o <= 1'b1;
               word_o <= w;
               rises_o <= rises + {4'h0, rise};
               frame_o <= fr_first;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/test_sofs_top.sv
// Bench: control port tasks, sample pushes, captured word checks.
// Assumes the capture model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sofs_top;
   logic clk_i, rst_b_i, sample_clk_i, sample_valid_i, spi_sclk_i, psl_i, sd_drv, samp_en;
   logic sample_ready_o, sdio_o, sdio_oe_b_o, pd_o, cap_v, cap_f, last_fr;
   logic [15:0] sample_data_i, cap_w;
   logic [4:0] cap_r;
   logic [7:0] rd;
   sofs_pkg::sofs_link_t link_o;
   sofs_pkg::sofs_mode_t mode;
   int errors, samples_checked, exp_rises, nwords, n;
   logic [15:0] exp_q[$];
   logic [7:0] codes [18] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h34, 8'h24,
      8'h14, 8'h04, 8'h40, 8'h32, 8'h22, 8'h12, 8'h02, 8'h36,
      8'h26, 8'h16, 8'h06, 8'h42};
   // Bench drives the data pin whenever the design releases it
   wire sdio_w = !sdio_oe_b_o ? sdio_o : sd_drv;

   sofs_top sofs_top_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .sample_clk_i(sample_clk_i),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
      .sample_data_i(sample_data_i), .spi_sclk_i(spi_sclk_i), .port_select_low_i(psl_i),
      .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_b_o(sdio_oe_b_o), .link_o(link_o),
      .common_mode_reference_pd_o(pd_o)
   );
   sofs_capture sofs_capture_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .link_i(link_o), .mode_i(mode),
      .word_valid_o(cap_v), .word_o(cap_w), .rises_o(cap_r), .frame_o(cap_f)
   );

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Sample clock only runs while the bench lets frames out
   initial begin
      sample_clk_i = 1'b0;
      #3.3;
      forever begin
         #80;
         sample_clk_i = samp_en ? ~sample_clk_i : 1'b0;
      end
   end

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic spi(input logic r, input logic [12:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      logic [23:0] sh;
      sh = {r, 2'b00, a, d};
      q = 8'h00;
      @(posedge clk_i);
      #1 psl_i = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sd_drv = (r && i < 8) ? 1'b0 : sh[i];
         repeat (8) @(posedge clk_i);
         #1;
         if (r && i < 8) begin
            q[i] = sdio_o;
            chk("data pin enable", 0, sdio_oe_b_o);
         end
         spi_sclk_i = 1'b1;
         repeat (8) @(posedge clk_i);
         #1 spi_sclk_i = 1'b0;
      end
      sd_drv = 1'b0;
      repeat (8) @(posedge clk_i);
      #1 psl_i = 1'b1;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic push(input logic [15:0] w);
      @(posedge clk_i);
      #1 sample_valid_i = 1'b1;
      sample_data_i = w;
      while (sample_ready_o !== 1'b1) begin
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      #1 sample_valid_i = 1'b0;
      exp_q.push_back(mode.word12 ? {w[15:4], 4'h0} : w);
   endtask

   task automatic wait_words(input int k);
      int t;
      t = nwords + k;
      samp_en = 1'b1;
      for (int c = 0; c < 200 * k && nwords < t; c++) @(posedge clk_i);
      #1 samp_en = 1'b0;
      chk("words seen", t, nwords);
      chk("words left", 0, exp_q.size());
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      if (cap_v === 1'b1) begin
         chk("word", exp_q.size() ? exp_q.pop_front() : 16'hxxxx, cap_w);
         chk("clock rises", exp_rises, cap_r);
         if (!mode.frame2x) chk("frame flag", 1, cap_f);
         else if (nwords % 2) chk("frame alternate", !last_fr, cap_f);
         last_fr = cap_f;
         nwords++;
      end
   end

   initial begin
      #200000;
      errors++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test();
   end

   initial begin
      rst_b_i = 1'b0;
      sample_valid_i = 1'b0;
      sample_data_i = 16'h0000;
      spi_sclk_i = 1'b0;
      psl_i = 1'b1;
      sd_drv = 1'b0;
      samp_en = 1'b0;
      mode = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      exp_rises = 4;
      repeat (10) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      repeat (4) @(posedge clk_i);
      spi(1, sofs_pkg::ADDR_SER_CTL, 8'h00, rd);
      chk("ctl reset", 8'h30, rd);
      spi(1, sofs_pkg::ADDR_UIO3, 8'h00, rd);
      chk("io3 reset", sofs_pkg::RST_UIO3, rd);
      chk("pd reset", 0, pd_o);
      push(16'h9a3c);
      wait_words(1);
      $display("test defaults done");
      spi(0, sofs_pkg::ADDR_UIO3, 8'h08, rd);
      chk("pd set", 1, pd_o);
      spi(1, sofs_pkg::ADDR_UIO3, 8'h00, rd);
      chk("io3 read", 8'h08, rd);
      spi(0, sofs_pkg::ADDR_UIO3, 8'h00, rd);
      chk("pd clear", 0, pd_o);
      spi(0, 13'h055, 8'hff, rd);
      spi(1, 13'h055, 8'h00, rd);
      chk("unmapped", 0, rd);
      $display("test registers done");
      foreach (codes[k]) begin
         // Port stays quiet while frames run
         spi(0, sofs_pkg::ADDR_SER_CTL, codes[k], rd);
         spi(1, sofs_pkg::ADDR_SER_CTL, 8'h00, rd);
         chk("ctl", codes[k], rd);
         // One-lane codes always run at double data rate
         mode = '{codes[k][1], codes[k][2], codes[k][4], codes[k][6],
                  codes[k][5] | codes[k][6]};
         n = codes[k][6] ? (codes[k][1] ? 12 : 16) : (codes[k][1] ? 6 : 8);
         exp_rises = mode.ddr ? n / 2 : n;
         nwords = 0;
         push({codes[k], ~codes[k]} ^ 16'h5a69);
         push(16'hc3a5 + {8'h00, codes[k]});
         wait_words(2);
         $display("test code %h done", codes[k]);
      end
      spi(0, sofs_pkg::ADDR_SER_CTL, 8'h30, rd);
      mode = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      exp_rises = 4;
      for (int i = 0; i < 8; i++) push(16'h1e00 + 16'(i));
      chk("ready full", 0, sample_ready_o);
      wait_words(8);
      chk("ready drained", 1, sample_ready_o);
      $display("test buffer done");
      stop_test();
   end
endmodule
`default_nettype wire
